/* File: rtl/cel_pkg.sv */
package cel_pkg;
   localparam int DATA_W = 32;
   localparam int ADDR_W = 5;
   localparam int CMD_W  = 23;

   // Register port word indices
   localparam logic [4:0] REG_ACC    = 5'h00, REG_CNT   = 5'h01, REG_DEXT  = 5'h02;
   localparam logic [4:0] REG_BASE   = 5'h03, REG_STK   = 5'h04, REG_FRM   = 5'h05;
   localparam logic [4:0] REG_SRCI   = 5'h06, REG_DSTI  = 5'h07, REG_ESEG  = 5'h08;
   localparam logic [4:0] REG_CSEG   = 5'h09, REG_SSEG  = 5'h0a, REG_DSEG  = 5'h0b;
   localparam logic [4:0] REG_IPTR   = 5'h0c, REG_FLAGS = 5'h0d, REG_CMD   = 5'h0e;
   localparam logic [4:0] REG_IMM    = 5'h0f, REG_EA    = 5'h10, REG_STATUS = 5'h11;

   localparam logic [1:0] SEG_ES = 2'h0, SEG_CS = 2'h1, SEG_SS = 2'h2, SEG_DS = 2'h3;

   // Flag bit positions and the bits that exist
   localparam int FL_CF = 0, FL_PF = 2, FL_AF = 4, FL_ZF = 6, FL_SF = 7, FL_DF = 10, FL_OF = 11;
   localparam logic [15:0] FLAGS_DEF_MASK = 16'h0fd5;

   // Command word field positions
   localparam int CF_OP = 0, CF_WIDE = 5, CF_DKIND = 6, CF_DIDX = 8, CF_SKIND = 11;
   localparam int CF_SIDX = 13, CF_OVR = 16, CF_OSEG = 17, CF_REP = 19, CF_LEN = 20;

   localparam logic [15:0] RST_WORD     = 16'h0000;
   localparam logic [15:0] RST_FLAGS    = 16'h0000;
   localparam logic [15:0] STK_STEP     = 16'h0002;
   localparam logic [15:0] STEP_WORD    = 16'h0002;
   localparam logic [15:0] STEP_BYTE    = 16'h0001;
   localparam logic [2:0]  POP_ALL_LAST = 3'h7;
   localparam logic [2:0]  POP_ALL_SKIP = 3'h4;
   localparam logic [7:0]  ONES_B       = 8'hff;
   localparam logic [15:0] ONES_W       = 16'hffff;
   localparam logic [7:0]  NEG_MIN_B    = 8'h80;
   localparam logic [15:0] NEG_MIN_W    = 16'h8000;

   typedef enum logic [4:0] {
      OP_LOOP_NZ, OP_COPY, OP_STR_COPY, OP_UMUL, OP_TWOS_CPL, OP_IDLE, OP_INVERT,
      OP_UNION, OP_PORT_IMM, OP_PORT_DEXT, OP_STR_PORT, OP_REMOVE, OP_RESTORE_ALL,
      OP_RESTORE_FLAGS, OP_STORE
   } cel_op_t;

   typedef enum logic [1:0] {K_REG, K_SEG, K_MEM, K_IMM} cel_kind_t;
endpackage : cel_pkg

/* File: rtl/cel_alu_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface cel_alu_if;
   import cel_pkg::*;
   cel_op_t     op;
   logic        wide;
   logic [15:0] a;
   logic [15:0] b;
   logic [15:0] flags_in;
   logic [15:0] res;
   logic [15:0] res_hi;
   logic [15:0] flags_out;
   modport core (output op, wide, a, b, flags_in, input res, res_hi, flags_out);
   modport alu  (input op, wide, a, b, flags_in, output res, res_hi, flags_out);
endinterface : cel_alu_if
`default_nettype wire

/* File: rtl/cel_alu.sv */
`timescale 1ns/100ps
`default_nettype none
module cel_alu (
   cel_alu_if.alu p
);
   import cel_pkg::*;

   logic [16:0] neg_w;
   logic [8:0]  neg_b;
   logic [31:0] prod;

   always_comb begin
      p.res       = p.b;
      p.res_hi    = 16'h0000;
      p.flags_out = p.flags_in;
      neg_w       = 17'h00000;
      neg_b       = 9'h000;
      prod        = 32'h00000000;
      unique case (p.op)
         OP_TWOS_CPL: begin
            neg_w = {1'b0, ONES_W - p.a} + 17'h00001; // RL7
            neg_b = {1'b0, ONES_B - p.a[7:0]} + 9'h001; // RL7
            p.res = p.wide ? neg_w[15:0] : {8'h00, neg_b[7:0]};
            p.flags_out[FL_CF] = p.wide ? (p.a != 16'h0000) : (p.a[7:0] != 8'h00); // RL7
            p.flags_out[FL_AF] = (p.a[3:0] != 4'h0); // RL7
            // Most negative value maps onto itself, so the only sign of it is overflow
            p.flags_out[FL_OF] = p.wide ? (p.a == NEG_MIN_W) : (p.a[7:0] == NEG_MIN_B); // RL8
         end
         OP_INVERT: begin
            p.res = p.wide ? ONES_W - p.a : {8'h00, ONES_B - p.a[7:0]}; // RL10
         end
         OP_UNION: begin
            p.res = p.wide ? (p.a | p.b) : {8'h00, p.a[7:0] | p.b[7:0]}; // RL11
            p.flags_out[FL_CF] = 1'b0; // RL11
            p.flags_out[FL_OF] = 1'b0; // RL11
         end
         OP_UMUL: begin
            prod = p.wide ? {16'h0000, p.a} * {16'h0000, p.b} // RL5
                          : {16'h0000, {8'h00, p.a[7:0]} * {8'h00, p.b[7:0]}}; // RL4
            p.res    = prod[15:0];
            p.res_hi = prod[31:16];
            p.flags_out[FL_CF] = p.wide ? (prod[31:16] != 16'h0000) : (prod[15:8] != 8'h00); // RL6
            p.flags_out[FL_OF] = p.flags_out[FL_CF]; // RL6
         end
         default: begin
         end
      endcase
      if (p.op == OP_TWOS_CPL || p.op == OP_UNION) begin
         p.flags_out[FL_PF] = ~^p.res[7:0]; // RL11
         p.flags_out[FL_SF] = p.wide ? p.res[15] : p.res[7]; // RL11
         p.flags_out[FL_ZF] = p.wide ? (p.res == 16'h0000) : (p.res[7:0] == 8'h00); // RL11
      end
   end
endmodule : cel_alu
`default_nettype wire

/* File: rtl/cel_exec_core.sv */
// Notes on behaviour
// RL1: loop: count minus one, branch if nonzero, zero clear
// RL2: copy moves byte or word, flags untouched
// RL3: string copy moves element, advances both indexes
// RL4: byte multiply: low accumulator times source, accumulator
// RL5: word multiply: high in data extension, low accumulator
// RL6: multiply sets carry, overflow when upper half nonzero
// RL7: negate as all-ones minus operand plus one
// RL8: most negative stays, overflow set; zero stays
// RL9: idle only advances instruction pointer
// RL10: invert is all-ones minus operand, flags kept
// RL11: union: OR, clear carry, overflow, update rest
// RL12: port write from accumulator, immediate or extension port
// RL13: string port write reads source index, segment overridable
// RL14: string port source index steps by direction flag
// RL15: remove loads word, stack plus two, never code segment
// RL16: restore all pops eight words, one discarded
// RL17: restore flags loads defined bits, stack plus two
// RL18: store: stack minus two, then write word
// RL19: listed instructions never change any flag
// RL20: stack words: low byte first, high byte next
`timescale 1ns/100ps
`default_nettype none
module cel_exec_core (
   input  wire logic                       clk_sys_i,
   input  wire logic                       rst_n_i,
   input  wire logic [cel_pkg::ADDR_W-1:0] reg_addr_i,
   input  wire logic [cel_pkg::DATA_W-1:0] reg_wdata_i,
   input  wire logic                       reg_wr_i,
   input  wire logic                       reg_rd_i,
   output var  logic [cel_pkg::DATA_W-1:0] reg_rdata_o,
   output var  logic                       mem_req_o,
   output var  logic                       mem_we_o,
   output var  logic                       mem_io_o,
   output var  logic [19:0]                mem_addr_o,
   output var  logic [7:0]                 mem_wdata_o,
   input  wire logic                       mem_ack_i,
   input  wire logic [7:0]                 mem_rdata_i,
   output var  logic                       busy_o
);
   import cel_pkg::*;

   typedef enum logic [2:0] {S_IDLE, S_DECODE, S_READ, S_EXEC, S_WRITE} cel_state_t;

   cel_state_t       state_r;
   cel_state_t       state_nxt;
   logic [15:0]      gp_r [0:7];
   logic [15:0]      sg_r [0:3];
   logic [15:0]      ip_r;
   logic [15:0]      flags_r;
   logic [15:0]      imm_r;
   logic [15:0]      ea_r;
   logic [15:0]      mem_data_r;
   logic [15:0]      wr_data_r;
   logic [CMD_W-1:0] cmd_r;
   logic             illegal_r;
   logic             byte_r;
   logic [2:0]       pop_cnt_r;

   cel_op_t          op;
   cel_kind_t        dkind;
   cel_kind_t        skind;
   logic             wide;
   logic             ovr;
   logic             iteration_prefix;
   logic [2:0]       didx;
   logic [2:0]       sidx;
   logic [1:0]       oseg;
   logic [2:0]       len;
   logic             cmd_wr;
   logic             sw_wr;
   logic             is_str;
   logic             is_stack;
   logic             port_op;
   logic             acc_wide;
   logic             need_read;
   logic             need_write;
   logic             illegal_cmd;
   logic             rep_skip;
   logic             rep_again;
   logic             exec_more;
   logic             ack_now;
   logic             byte_last;
   logic             elem_done;
   logic             op_done;
   logic             loop_take;
   logic             dst_we;
   logic [15:0]      dst_wdata;
   logic [15:0]      cnt_dec;
   logic [15:0]      step;
   logic [15:0]      delta;
   logic [15:0]      acc_val;
   logic [15:0]      src_val;
   logic [15:0]      dst_val;
   logic [15:0]      seg_base;
   logic [15:0]      offs;
   logic [19:0]      phys;
   logic [2:0]       pop_idx;
   cel_alu_if        alu_bus ();

   assign op    = cel_op_t'(cmd_r[CF_OP +: 5]);
   assign wide  = cmd_r[CF_WIDE];
   assign dkind = cel_kind_t'(cmd_r[CF_DKIND +: 2]);
   assign didx  = cmd_r[CF_DIDX +: 3];
   assign skind = cel_kind_t'(cmd_r[CF_SKIND +: 2]);
   assign sidx  = cmd_r[CF_SIDX +: 3];
   assign ovr   = cmd_r[CF_OVR];
   assign oseg  = cmd_r[CF_OSEG +: 2];
   assign iteration_prefix   = cmd_r[CF_REP];
   assign len   = cmd_r[CF_LEN +: 3];

   assign cmd_wr   = reg_wr_i & (reg_addr_i == REG_CMD) & (state_r == S_IDLE);
   // Architectural state is frozen to software while an instruction runs
   assign sw_wr    = reg_wr_i & (state_r == S_IDLE);
   assign is_str   = (op == OP_STR_COPY) | (op == OP_STR_PORT);
   assign is_stack = op inside {OP_REMOVE, OP_RESTORE_ALL, OP_RESTORE_FLAGS, OP_STORE};
   assign port_op  = op inside {OP_PORT_IMM, OP_PORT_DEXT, OP_STR_PORT};
   assign acc_wide = wide | is_stack;

   assign need_read = is_str | (is_stack & (op != OP_STORE))
                    | ((op inside {OP_COPY, OP_UMUL, OP_STORE, OP_UNION}) & (skind == K_MEM))
                    | ((op inside {OP_TWOS_CPL, OP_INVERT, OP_UNION}) & (dkind == K_MEM));
   assign need_write = is_str | (op inside {OP_PORT_IMM, OP_PORT_DEXT, OP_STORE})
                     | ((op inside {OP_COPY, OP_TWOS_CPL, OP_INVERT, OP_UNION, OP_REMOVE})
                        & (dkind == K_MEM));
   // Only one memory operand buffer, so memory-to-memory forms are refused
   assign illegal_cmd = (cmd_r[CF_OP +: 5] > OP_STORE)
                      | ((op == OP_REMOVE) & (dkind == K_SEG) & (didx[1:0] == SEG_CS)) // RL15
                      | ((skind == K_MEM) & (dkind == K_MEM));

   assign cnt_dec   = gp_r[REG_CNT[2:0]] - 16'h0001;
   assign rep_skip  = iteration_prefix & is_str & (gp_r[REG_CNT[2:0]] == 16'h0000);
   assign rep_again = iteration_prefix & is_str & (cnt_dec != 16'h0000);
   assign pop_idx   = POP_ALL_LAST - pop_cnt_r;
   assign exec_more = (op == OP_RESTORE_ALL) & (pop_cnt_r != POP_ALL_LAST); // RL16
   assign ack_now   = mem_req_o & mem_ack_i;
   assign byte_last = byte_r | ~acc_wide;
   assign elem_done = (state_r == S_WRITE) & ack_now & byte_last & is_str;
   assign op_done   = ((state_r == S_DECODE) & rep_skip & ~illegal_cmd)
                    | ((state_r == S_EXEC) & ~need_write & ~exec_more)
                    | ((state_r == S_WRITE) & ack_now & byte_last & ~rep_again);
   assign loop_take = (op == OP_LOOP_NZ) & (cnt_dec != 16'h0000) & ~flags_r[FL_ZF]; // RL1
   assign step      = acc_wide ? STEP_WORD : STEP_BYTE;
   assign delta     = flags_r[FL_DF] ? 16'h0000 - step : step; // RL14
   assign acc_val   = wide ? gp_r[REG_ACC[2:0]] : {8'h00, gp_r[REG_ACC[2:0]][7:0]}; // RL12
   assign dst_we    = (state_r == S_EXEC)
                    & (op inside {OP_COPY, OP_TWOS_CPL, OP_INVERT, OP_UNION, OP_REMOVE});
   assign dst_wdata = (op == OP_REMOVE) ? mem_data_r : alu_bus.res;

   function automatic logic [15:0] gp_rd(input logic [2:0] idx, input logic w);
      if (w) begin
         return gp_r[idx];
      end else if (idx[2]) begin
         return {8'h00, gp_r[{1'b0, idx[1:0]}][15:8]};
      end else begin
         return {8'h00, gp_r[{1'b0, idx[1:0]}][7:0]};
      end
   endfunction : gp_rd

   always_comb begin
      unique case (skind)
         K_REG:   src_val = gp_rd(sidx, acc_wide);
         K_SEG:   src_val = sg_r[sidx[1:0]];
         K_MEM:   src_val = mem_data_r;
         K_IMM:   src_val = imm_r;
      endcase
      unique case (dkind)
         K_REG:   dst_val = gp_rd(didx, acc_wide);
         K_SEG:   dst_val = sg_r[didx[1:0]];
         K_MEM:   dst_val = mem_data_r;
         K_IMM:   dst_val = 16'h0000;
      endcase
   end

   assign alu_bus.op       = op;
   assign alu_bus.wide     = wide;
   assign alu_bus.a        = (op == OP_UMUL) ? gp_r[REG_ACC[2:0]] : dst_val; // RL4
   assign alu_bus.b        = src_val;
   assign alu_bus.flags_in = flags_r;

   cel_alu u_alu (
      .p (alu_bus)
   );

   always_comb begin
      seg_base = sg_r[ovr ? oseg : SEG_DS];
      offs     = ea_r;
      if (state_r == S_READ) begin
         if (is_str) begin
            offs = gp_r[REG_SRCI[2:0]]; // RL13
         end else if (is_stack) begin
            seg_base = sg_r[SEG_SS];
            offs     = gp_r[REG_STK[2:0]];
         end
      end else begin
         if (op == OP_STR_COPY) begin
            seg_base = sg_r[SEG_ES]; // RL3
            offs     = gp_r[REG_DSTI[2:0]];
         end else if (op == OP_STORE) begin
            seg_base = sg_r[SEG_SS];
            offs     = gp_r[REG_STK[2:0]];
         end else if (op == OP_PORT_IMM) begin
            offs = {8'h00, imm_r[7:0]}; // RL12
         end else if (port_op) begin
            offs = gp_r[REG_DEXT[2:0]]; // RL12
         end
      end
      offs = offs + {15'h0000, byte_r}; // RL20
      phys = {seg_base, 4'h0} + {4'h0, offs};
   end

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         S_IDLE:   if (cmd_wr) state_nxt = S_DECODE;
         S_DECODE: begin
            if (illegal_cmd | rep_skip) state_nxt = S_IDLE;
            else if (need_read)         state_nxt = S_READ;
            else                        state_nxt = S_EXEC;
         end
         S_READ:   if (ack_now & byte_last) state_nxt = S_EXEC;
         S_EXEC: begin
            if (need_write)     state_nxt = S_WRITE;
            else if (exec_more) state_nxt = S_READ; // RL16
            else                state_nxt = S_IDLE;
         end
         S_WRITE:  if (ack_now & byte_last) state_nxt = rep_again ? S_READ : S_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         state_r <= S_IDLE;
         busy_o  <= 1'b0;
      end else begin
         state_r <= state_nxt;
         busy_o  <= (state_nxt != S_IDLE);
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         byte_r    <= 1'b0;
         pop_cnt_r <= 3'h0;
      end else begin
         if (ack_now) byte_r <= ~byte_last;
         if (state_r == S_DECODE) pop_cnt_r <= 3'h0;
         else if ((state_r == S_EXEC) & exec_more) pop_cnt_r <= pop_cnt_r + 3'h1;
      end
   end

   // One byte per handshake with an idle cycle between bytes; slower, but
   // every address is formed from settled register values
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         mem_req_o   <= 1'b0;
         mem_we_o    <= 1'b0;
         mem_io_o    <= 1'b0;
         mem_addr_o  <= 20'h00000;
         mem_wdata_o <= 8'h00;
      end else if (ack_now) begin
         mem_req_o <= 1'b0;
      end else if (!mem_req_o && (state_r == S_READ || state_r == S_WRITE)) begin
         mem_req_o   <= 1'b1;
         mem_we_o    <= (state_r == S_WRITE);
         mem_io_o    <= (state_r == S_WRITE) & port_op; // RL12
         mem_addr_o  <= ((state_r == S_WRITE) & port_op) ? {4'h0, offs} : phys;
         mem_wdata_o <= byte_r ? wr_data_r[15:8] : wr_data_r[7:0]; // RL20
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         mem_data_r <= RST_WORD;
      end else if ((state_r == S_READ) & ack_now) begin
         if (byte_r) mem_data_r[15:8] <= mem_rdata_i;
         else        mem_data_r       <= {8'h00, mem_rdata_i};
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         wr_data_r <= RST_WORD;
      end else if (state_r == S_EXEC) begin
         if (port_op & ~is_str)            wr_data_r <= acc_val; // RL12
         else if (is_str | (op == OP_REMOVE)) wr_data_r <= mem_data_r; // RL3
         else                              wr_data_r <= alu_bus.res; // RL18
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         cmd_r <= '0;
         imm_r <= RST_WORD;
         ea_r  <= RST_WORD;
      end else begin
         if (cmd_wr)                         cmd_r <= reg_wdata_i[CMD_W-1:0];
         if (sw_wr & (reg_addr_i == REG_IMM)) imm_r <= reg_wdata_i[15:0];
         if (sw_wr & (reg_addr_i == REG_EA))  ea_r  <= reg_wdata_i[15:0];
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i)                  illegal_r <= 1'b0;
      else if (state_r == S_DECODE)  illegal_r <= illegal_cmd; // RL15
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         for (int i = 0; i < 8; i++) gp_r[i] <= RST_WORD;
         for (int i = 0; i < 4; i++) sg_r[i] <= RST_WORD;
      end else begin
         if (sw_wr & (reg_addr_i < REG_ESEG)) gp_r[reg_addr_i[2:0]] <= reg_wdata_i[15:0];
         if (sw_wr & (reg_addr_i[4:2] == 3'h2)) sg_r[reg_addr_i[1:0]] <= reg_wdata_i[15:0];
         if (state_r == S_EXEC) begin
            unique case (op)
               OP_LOOP_NZ: gp_r[REG_CNT[2:0]] <= cnt_dec; // RL1
               OP_UMUL: begin
                  gp_r[REG_ACC[2:0]] <= alu_bus.res; // RL4
                  if (wide) gp_r[REG_DEXT[2:0]] <= alu_bus.res_hi; // RL5
               end
               OP_REMOVE, OP_RESTORE_FLAGS: begin
                  gp_r[REG_STK[2:0]] <= gp_r[REG_STK[2:0]] + STK_STEP; // RL15 RL17
               end
               OP_RESTORE_ALL: begin
                  gp_r[REG_STK[2:0]] <= gp_r[REG_STK[2:0]] + STK_STEP; // RL16
                  if (pop_idx != POP_ALL_SKIP) gp_r[pop_idx] <= mem_data_r; // RL16
               end
               OP_STORE: gp_r[REG_STK[2:0]] <= gp_r[REG_STK[2:0]] - STK_STEP; // RL18
               default: begin
               end
            endcase
         end
         // Placed after the stack step so a removed word wins over it
         if (dst_we & (dkind == K_REG)) begin
            if (acc_wide)     gp_r[didx] <= dst_wdata; // RL2
            else if (didx[2]) gp_r[{1'b0, didx[1:0]}][15:8] <= dst_wdata[7:0];
            else              gp_r[{1'b0, didx[1:0]}][7:0] <= dst_wdata[7:0];
         end
         if (dst_we & (dkind == K_SEG)) sg_r[didx[1:0]] <= dst_wdata; // RL2 RL15
         if (elem_done) begin
            gp_r[REG_SRCI[2:0]] <= gp_r[REG_SRCI[2:0]] + delta; // RL3 RL14
            if (op == OP_STR_COPY) gp_r[REG_DSTI[2:0]] <= gp_r[REG_DSTI[2:0]] + delta; // RL3
            if (iteration_prefix) gp_r[REG_CNT[2:0]] <= cnt_dec;
         end
      end
   end

   // Flags change only for the arithmetic, union and restore-flags cases
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         flags_r <= RST_FLAGS;
      end else if (sw_wr & (reg_addr_i == REG_FLAGS)) begin
         flags_r <= reg_wdata_i[15:0] & FLAGS_DEF_MASK;
      end else if (state_r == S_EXEC) begin
         if (op inside {OP_TWOS_CPL, OP_UNION, OP_UMUL}) flags_r <= alu_bus.flags_out; // RL6 RL19
         else if (op == OP_RESTORE_FLAGS) flags_r <= mem_data_r & FLAGS_DEF_MASK; // RL17
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         ip_r <= RST_WORD;
      end else if (sw_wr & (reg_addr_i == REG_IPTR)) begin
         ip_r <= reg_wdata_i[15:0];
      end else if (op_done) begin
         ip_r <= ip_r + {13'h0000, len} // RL9
               + (loop_take ? {{8{imm_r[7]}}, imm_r[7:0]} : 16'h0000); // RL1
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         reg_rdata_o <= '0;
      end else begin
         reg_rdata_o <= '0;
         if (reg_rd_i) begin
            if (reg_addr_i < REG_ESEG) begin
               reg_rdata_o <= {16'h0000, gp_r[reg_addr_i[2:0]]};
            end else if (reg_addr_i < REG_IPTR) begin
               reg_rdata_o <= {16'h0000, sg_r[reg_addr_i[1:0]]};
            end else begin
               unique case (reg_addr_i)
                  REG_IPTR:   reg_rdata_o <= {16'h0000, ip_r};
                  REG_FLAGS:  reg_rdata_o <= {16'h0000, flags_r};
                  REG_CMD:    reg_rdata_o <= {{(DATA_W-CMD_W){1'b0}}, cmd_r};
                  REG_IMM:    reg_rdata_o <= {16'h0000, imm_r};
                  REG_EA:     reg_rdata_o <= {16'h0000, ea_r};
                  REG_STATUS: reg_rdata_o <= {30'h00000000, illegal_r, state_r != S_IDLE};
                  default:    reg_rdata_o <= '0;
               endcase
            end
         end
      end
   end
endmodule : cel_exec_core
`default_nettype wire

/* File: bench/cel_exec_checker.sv */
`timescale 1ns/100ps
`default_nettype none
module cel_exec_checker import cel_pkg::*; (
   input wire logic              clk_sys_i,
   input wire logic              rst_n_i,
   input wire logic [ADDR_W-1:0] reg_addr_i,
   input wire logic [DATA_W-1:0] reg_wdata_i,
   input wire logic              reg_wr_i,
   input wire logic              reg_rd_i,
   input wire logic [DATA_W-1:0] reg_rdata_o,
   input wire logic              mem_req_o,
   input wire logic              mem_we_o,
   input wire logic              mem_io_o,
   input wire logic [19:0]       mem_addr_o,
   input wire logic              mem_ack_i,
   input wire logic              busy_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);
   wire logic cmd_go = reg_wr_i && reg_addr_i == REG_CMD && !busy_o;
   chk_rdata_quiet: assert property (!reg_rd_i |=> reg_rdata_o == '0)
      else $error("stray read data");
   chk_req_hold: assert property (mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o))
      else $error("request not held");
   chk_ack_drop: assert property (mem_req_o && mem_ack_i |=> !mem_req_o)
      else $error("request after ack");
   chk_io_write: assert property (mem_req_o && mem_io_o |-> mem_we_o)
      else $error("port read");
   chk_req_busy: assert property (mem_req_o |-> busy_o)
      else $error("request while idle");
   chk_idle_walk: assert property (cmd_go && reg_wdata_i[4:0] == OP_IDLE
      |=> (busy_o && !mem_req_o) [*2] ##1 !busy_o)
      else $error("idle walk wrong");
   chk_loop_walk: assert property (cmd_go && reg_wdata_i[4:0] == OP_LOOP_NZ
      |=> (busy_o && !mem_req_o) [*2] ##1 !busy_o)
      else $error("loop walk wrong");
   chk_bad_quiet: assert property (cmd_go && reg_wdata_i[4:0] > 5'h0e |=> !mem_req_o [*3])
      else $error("refused op used bus");
   chk_busy_rise: assert property (cmd_go && reg_wdata_i[4:0] <= 5'h0e |=> busy_o)
      else $error("op did not start");
endmodule : cel_exec_checker
bind cel_exec_core cel_exec_checker u_chk (.*);
`default_nettype wire

/* File: bench/cel_mem_model.sv */
`timescale 1ns/100ps
`default_nettype none
module cel_mem_model (
   input  wire logic        clk_sys_i,
   input  wire logic        mem_req_i,
   input  wire logic        mem_we_i,
   input  wire logic        mem_io_i,
   input  wire logic [19:0] mem_addr_i,
   input  wire logic [7:0]  mem_wdata_i,
   output var  logic        mem_ack_o = 1'b0,
   output var  logic [7:0]  mem_rdata_o = 8'h5a
);
   logic [7:0] mem_a [logic [19:0]];
   logic [7:0] io_a [logic [19:0]];
   logic       hold_r = 1'b0;
   // Address bit 1 set adds a wait cycle
   always @(posedge clk_sys_i) begin
      mem_ack_o <= 1'b0;
      mem_rdata_o <= ~mem_rdata_o;
      hold_r <= mem_req_i && !mem_ack_o && !hold_r;
      if (mem_req_i && !mem_ack_o && (hold_r || !mem_addr_i[1])) begin
         mem_ack_o <= 1'b1;
         if (mem_we_i && mem_io_i) io_a[mem_addr_i] = mem_wdata_i;
         else if (mem_we_i) mem_a[mem_addr_i] = mem_wdata_i;
         else mem_rdata_o <= mem_a.exists(mem_addr_i) ? mem_a[mem_addr_i] : 8'h00;
      end
   end
endmodule : cel_mem_model
`default_nettype wire

/* File: bench/cel_exec_core_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module cel_exec_core_tb_top;
   import cel_pkg::*;
   logic        clk_sys_i = 1'b0;
   logic        rst_n_i = 1'b0;
   logic [4:0]  reg_addr_i = '0;
   logic [31:0] reg_wdata_i = '0;
   logic        reg_wr_i = 1'b0;
   logic        reg_rd_i = 1'b0;
   logic [31:0] reg_rdata_o;
   logic        mem_req_o, mem_we_o, mem_io_o, mem_ack_i, busy_o;
   logic [19:0] mem_addr_o;
   logic [7:0]  mem_wdata_o, mem_rdata_i;
   int          fails = 0;
   int          n_tests = 0;
   cel_exec_core dut (.*);
   cel_mem_model u_mem (.clk_sys_i(clk_sys_i), .mem_req_i(mem_req_o), .mem_we_i(mem_we_o),
      .mem_io_i(mem_io_o), .mem_addr_i(mem_addr_o), .mem_wdata_i(mem_wdata_o),
      .mem_ack_o(mem_ack_i), .mem_rdata_o(mem_rdata_i));
   initial forever #12.5 clk_sys_i = ~clk_sys_i;
   task automatic summarize();
      if (fails == 0 && n_tests > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : summarize
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge clk_sys_i);
      reg_wr_i <= 1'b0;
      #1;
   endtask : wr
   task automatic rd(input logic [4:0] a, input logic [31:0] e, input string nm);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge clk_sys_i);
      reg_rd_i <= 1'b0;
      #1 chk(nm, reg_rdata_o, e);
   endtask : rd
   function automatic logic [31:0] cm(int op, int w, int dk, int di, int sk, int si);
      return op | w << CF_WIDE | dk << CF_DKIND | di << CF_DIDX | sk << CF_SKIND
         | si << CF_SIDX | 2 << CF_LEN;
   endfunction : cm
   task automatic run(input logic [31:0] c);
      int k;
      wr(REG_CMD, c);
      @(posedge clk_sys_i);
      #1;
      for (k = 0; k < 300 && busy_o !== 1'b0; k++) @(posedge clk_sys_i);
      chk("busy", busy_o, 0);
   endtask : run
   task automatic t_loop();
      wr(REG_IPTR, 16'h0010);
      wr(REG_CNT, 2);
      wr(REG_FLAGS, 0);
      wr(REG_IMM, 16'h00fc);
      run(cm(OP_LOOP_NZ, 1, 0, 0, 0, 0));
      rd(REG_CNT, 1, "count");
      rd(REG_IPTR, 16'h000e, "ip taken");
      wr(REG_CNT, 5);
      wr(REG_FLAGS, 16'h0040);
      run(cm(OP_LOOP_NZ, 1, 0, 0, 0, 0));
      rd(REG_IPTR, 16'h0010, "ip fall");
      rd(REG_FLAGS, 16'h0040, "loop flags");
   endtask : t_loop
   task automatic t_arith();
      wr(REG_ACC, 16'h00f0);
      wr(REG_CNT, 16'h0011);
      wr(REG_FLAGS, 0);
      run(cm(OP_UMUL, 0, K_REG, 0, K_REG, 1));
      rd(REG_ACC, 16'h0ff0, "mul byte");
      rd(REG_FLAGS, 16'h0801, "mul flags");
      wr(REG_ACC, 16'h1234);
      wr(REG_CNT, 16'h0100);
      run(cm(OP_UMUL, 1, K_REG, 0, K_REG, 1));
      rd(REG_DEXT, 16'h0012, "mul high");
      rd(REG_ACC, 16'h3400, "mul low");
      wr(REG_ACC, 16'h0080);
      run(cm(OP_TWOS_CPL, 0, K_REG, 0, K_REG, 0));
      rd(REG_ACC, 16'h0080, "neg min");
      rd(REG_FLAGS, 16'h0881, "neg min flags");
      wr(REG_ACC, 16'h0001);
      run(cm(OP_TWOS_CPL, 1, K_REG, 0, K_REG, 0));
      rd(REG_ACC, 16'hffff, "neg");
      rd(REG_FLAGS, 16'h0095, "neg flags");
      wr(REG_ACC, 16'h00f0);
      wr(REG_CNT, 16'h0f00);
      wr(REG_FLAGS, 16'h0801);
      run(cm(OP_UNION, 1, K_REG, 0, K_REG, 1));
      rd(REG_ACC, 16'h0ff0, "union");
      rd(REG_FLAGS, 16'h0004, "union flags");
      run(cm(OP_INVERT, 1, K_REG, 0, K_REG, 0));
      run(cm(OP_IDLE, 0, 0, 0, 0, 0));
      rd(REG_ACC, 16'hf00f, "invert");
      rd(REG_FLAGS, 16'h0004, "invert flags");
      rd(5'h1f, 0, "unmapped");
   endtask : t_arith
   task automatic t_stack();
      wr(REG_STK, 16'h0100);
      wr(REG_BASE, 16'hbeef);
      run(cm(OP_STORE, 1, K_REG, 3, K_REG, 3));
      rd(REG_STK, 16'h00fe, "store sp");
      chk("low byte", u_mem.mem_a[20'h000fe], 8'hef);
      chk("high byte", u_mem.mem_a[20'h000ff], 8'hbe);
      run(cm(OP_REMOVE, 1, K_REG, 7, K_REG, 7));
      rd(REG_DSTI, 16'hbeef, "remove");
      rd(REG_STK, 16'h0100, "remove sp");
      run(cm(OP_REMOVE, 1, K_SEG, 1, K_SEG, 1));
      rd(REG_STATUS, 2, "remove code seg");
   endtask : t_stack
   task automatic t_port();
      wr(REG_DEXT, 16'h1234);
      wr(REG_ACC, 16'ha55a);
      run(cm(OP_PORT_DEXT, 1, 0, 0, 0, 0));
      chk("port low", u_mem.io_a[20'h01234], 8'h5a);
      chk("port high", u_mem.io_a[20'h01235], 8'ha5);
   endtask : t_port
   initial begin
      repeat (2) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      @(posedge clk_sys_i);
      t_loop();
      t_arith();
      t_stack();
      t_port();
      summarize();
   end
   initial begin
      repeat (20000) @(posedge clk_sys_i);
      fails++;
      summarize();
   end
endmodule : cel_exec_core_tb_top
`default_nettype wire
